// ==== core/srx_pkg.sv ====
package srx_pkg;
	// operation codes presented by the decoder
	typedef enum logic [4:0] {
		OP_NONE,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_ARITHMETIC_RIGHT_SHIFT,
		OP_NIBBLE_SWAP,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_OVERFLOW_FLAG_SET,
		OP_OVERFLOW_FLAG_CLEAR,
		OP_SIGN_FLAG_SET,
		OP_SIGN_FLAG_CLEAR,
		OP_HALF_CARRY_SET,
		OP_HALF_CARRY_CLEAR,
		OP_ZERO_FLAG_SET,
		OP_ZERO_FLAG_CLEAR,
		OP_SLEEP,
		OP_WATCHDOG_RESTART,
		OP_BREAK
	} srx_op_t;

	// status flag bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;

	// values after reset
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// every listed operation completes in this many clocks
	localparam int unsigned OP_CYCLES = 1;
endpackage

// ==== core/srx_exec_unit.sv ====
`timescale 1ns/1ps
module srx_exec_unit (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic opValid,
	input wire srx_pkg::srx_op_t opCode,
	input wire logic [7:0] operand,
	input wire logic [2:0] bitSelect,
	input wire logic [7:0] flagsIn,
	output logic resultValid,
	output logic [7:0] result,
	output logic resultWrite,
	output logic [7:0] flagsOut,
	output logic sleepRequest,
	output logic watchdogRestart,
	output logic debugBreak
);
	import srx_pkg::*;

	// flag update for shifts and rotates: N from bit 7, V = N xor C, S = N xor V
	function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
			input logic c);
		logic [7:0] o;
		o = f;
		o[FLAG_C] = c;
		o[FLAG_Z] = (r == 8'h00);
		o[FLAG_N] = r[7];
		o[FLAG_V] = r[7] ^ c;
		o[FLAG_S] = r[7] ^ (r[7] ^ c);
		return o;
	endfunction

	// operation decode
	wire logic isRotateLeft = opValid && (opCode == OP_ROTATE_LEFT_CARRY);
	wire logic isRotateRight = opValid && (opCode == OP_ROTATE_RIGHT_CARRY);
	wire logic isLogicalShift = opValid && (opCode == OP_LOGICAL_RIGHT_SHIFT);
	wire logic isArithShift = opValid && (opCode == OP_ARITHMETIC_RIGHT_SHIFT);
	wire logic isSwap = opValid && (opCode == OP_NIBBLE_SWAP);
	wire logic isBitToFlag = opValid && (opCode == OP_BIT_TO_TRANSFER_FLAG);
	wire logic isFlagToBit = opValid && (opCode == OP_TRANSFER_FLAG_TO_BIT);
	wire logic isSleep = opValid && (opCode == OP_SLEEP);
	wire logic isWatchdog = opValid && (opCode == OP_WATCHDOG_RESTART);
	wire logic isBreak = opValid && (opCode == OP_BREAK);

	// shifted results
	wire logic [7:0] rotateLeftVal = {operand[6:0], flagsIn[FLAG_C]};
	wire logic [7:0] rotateRightVal = {flagsIn[FLAG_C], operand[7:1]};
	wire logic [7:0] logicalShiftVal = {1'b0, operand[7:1]};
	wire logic [7:0] arithShiftVal = {operand[7], operand[7:1]};
	wire logic [7:0] swapVal = {operand[3:0], operand[7:4]};
	wire logic [7:0] bitMask = 8'h01 << bitSelect;
	wire logic [7:0] flagToBitVal = flagsIn[FLAG_T] ? (operand | bitMask) : (operand & ~bitMask);

	logic [7:0] next_result;
	logic [7:0] next_flags;
	logic next_write;

	// result and flag selection
	always_comb begin
		next_result = operand;
		next_flags = flagsIn;
		next_write = 1'b0;
		if (opValid) begin
			case (opCode)
				OP_ROTATE_LEFT_CARRY: begin
					next_result = rotateLeftVal;
					next_flags = shift_flags(flagsIn, rotateLeftVal, operand[7]);
					next_write = 1'b1;
				end
				OP_ROTATE_RIGHT_CARRY: begin
					next_result = rotateRightVal;
					next_flags = shift_flags(flagsIn, rotateRightVal, operand[0]);
					next_write = 1'b1;
				end
				OP_LOGICAL_RIGHT_SHIFT: begin
					next_result = logicalShiftVal;
					next_flags = shift_flags(flagsIn, logicalShiftVal, operand[0]);
					next_write = 1'b1;
				end
				OP_ARITHMETIC_RIGHT_SHIFT: begin
					next_result = arithShiftVal;
					next_flags = shift_flags(flagsIn, arithShiftVal, operand[0]);
					next_write = 1'b1;
				end
				OP_NIBBLE_SWAP: begin
					next_result = swapVal;
					next_write = 1'b1;
				end
				OP_BIT_TO_TRANSFER_FLAG: next_flags[FLAG_T] = operand[bitSelect];
				OP_TRANSFER_FLAG_TO_BIT: begin
					next_result = flagToBitVal;
					next_write = 1'b1;
				end
				OP_OVERFLOW_FLAG_SET: next_flags[FLAG_V] = 1'b1;
				OP_OVERFLOW_FLAG_CLEAR: next_flags[FLAG_V] = 1'b0;
				OP_SIGN_FLAG_SET: next_flags[FLAG_S] = 1'b1;
				OP_SIGN_FLAG_CLEAR: next_flags[FLAG_S] = 1'b0;
				OP_HALF_CARRY_SET: next_flags[FLAG_H] = 1'b1;
				OP_HALF_CARRY_CLEAR: next_flags[FLAG_H] = 1'b0;
				OP_ZERO_FLAG_SET: next_flags[FLAG_Z] = 1'b1;
				OP_ZERO_FLAG_CLEAR: next_flags[FLAG_Z] = 1'b0;
				default: next_flags = flagsIn; // sleep, restart, break keep flags
			endcase
		end
	end

	// result and flag registers
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			result <= RESULT_RESET;
			flagsOut <= FLAGS_RESET;
			resultWrite <= 1'b0;
			resultValid <= 1'b0;
		end else begin
			result <= next_result;
			flagsOut <= next_flags;
			resultWrite <= next_write;
			resultValid <= opValid;
		end
	end

	// side requests to sleep, watchdog and debug logic, one-clock pulses
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sleepRequest <= 1'b0;
			watchdogRestart <= 1'b0;
			debugBreak <= 1'b0;
		end else begin
			sleepRequest <= isSleep;
			watchdogRestart <= isWatchdog;
			debugBreak <= isBreak;
		end
	end

	// checks
	property p_rotate_left;
		@(posedge clk_sys) disable iff (!resetn)
		isRotateLeft |=> result == {$past(operand[6:0]), $past(flagsIn[FLAG_C])}
			&& flagsOut[FLAG_C] == $past(operand[7]);
	endproperty
	a_rotate_left: assert property (p_rotate_left) else $error("rotate left wrong");

	property p_rotate_right;
		@(posedge clk_sys) disable iff (!resetn)
		isRotateRight |=> result == {$past(flagsIn[FLAG_C]), $past(operand[7:1])}
			&& flagsOut[FLAG_C] == $past(operand[0]) && flagsOut[FLAG_N] == result[7];
	endproperty
	a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");

	property p_bit_to_flag;
		@(posedge clk_sys) disable iff (!resetn)
		isBitToFlag |=> flagsOut[FLAG_T] == $past(operand[bitSelect])
			&& flagsOut[5:0] == $past(flagsIn[5:0])
			&& flagsOut[FLAG_I] == $past(flagsIn[FLAG_I]) && !resultWrite;
	endproperty
	a_bit_to_flag: assert property (p_bit_to_flag) else $error("bit store wrong");

	property p_flag_to_bit;
		@(posedge clk_sys) disable iff (!resetn)
		isFlagToBit |=> result[$past(bitSelect)] == $past(flagsIn[FLAG_T])
			&& flagsOut == $past(flagsIn);
	endproperty
	a_flag_to_bit: assert property (p_flag_to_bit) else $error("bit load wrong");

	property p_flagset;
		@(posedge clk_sys) disable iff (!resetn)
		(opValid && opCode == OP_OVERFLOW_FLAG_SET) |=> flagsOut == ($past(flagsIn) | 8'h08);
	endproperty
	a_flagset: assert property (p_flagset) else $error("overflow set wrong");

	property p_signclr;
		@(posedge clk_sys) disable iff (!resetn)
		(opValid && opCode == OP_SIGN_FLAG_CLEAR) |=> flagsOut == ($past(flagsIn) & 8'hEF);
	endproperty
	a_signclr: assert property (p_signclr) else $error("sign clear wrong");

	property p_halfset;
		@(posedge clk_sys) disable iff (!resetn)
		(opValid && opCode == OP_HALF_CARRY_SET) |=> flagsOut == ($past(flagsIn) | 8'h20);
	endproperty
	a_halfset: assert property (p_halfset) else $error("half carry set wrong");

	property p_zeroclr;
		@(posedge clk_sys) disable iff (!resetn)
		(opValid && opCode == OP_ZERO_FLAG_CLEAR) |=> flagsOut == ($past(flagsIn) & 8'hFD);
	endproperty
	a_zeroclr: assert property (p_zeroclr) else $error("zero clear wrong");

	property p_sleep;
		@(posedge clk_sys) disable iff (!resetn)
		isSleep |=> sleepRequest && flagsOut == $past(flagsIn) && !resultWrite;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep handling wrong");

	property p_watchdog;
		@(posedge clk_sys) disable iff (!resetn)
		watchdogRestart |-> $past(isWatchdog) && flagsOut == $past(flagsIn);
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog restart wrong");

	property p_break;
		@(posedge clk_sys) disable iff (!resetn)
		isBreak |=> debugBreak && flagsOut == $past(flagsIn);
	endproperty
	a_break: assert property (p_break) else $error("break handling wrong");

	property p_shift;
		@(posedge clk_sys) disable iff (!resetn)
		(isLogicalShift || isArithShift) |=> result[6:0] == $past(operand[7:1])
			&& result[7] == ($past(isArithShift) & $past(operand[7]))
			&& flagsOut[FLAG_C] == $past(operand[0]) && flagsOut[FLAG_Z] == (result == 8'h00);
	endproperty
	a_shift: assert property (p_shift) else $error("right shift wrong");

	property p_swap;
		@(posedge clk_sys) disable iff (!resetn)
		isSwap |=> result == {$past(operand[3:0]), $past(operand[7:4])}
			&& flagsOut == $past(flagsIn);
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");
endmodule

// ==== verif/srx_core_model.sv ====
`timescale 1ns/1ps
// register file entry and status flags that sit behind the execution unit
module srx_core_model (
	input wire logic clk_sys,
	input wire logic loadEn,
	input wire logic [7:0] loadReg,
	input wire logic [7:0] loadFlags,
	input wire logic resultValid,
	input wire logic resultWrite,
	input wire logic [7:0] result,
	input wire logic [7:0] flagsOut,
	output logic [7:0] operand,
	output logic [7:0] flagsIn
);
	// preload from the bench, otherwise write back what the unit returns
	always_ff @(posedge clk_sys) begin
		if (loadEn) begin
			operand <= loadReg;
			flagsIn <= loadFlags;
		end else if (resultValid) begin
			flagsIn <= flagsOut;
			if (resultWrite) begin
				operand <= result;
			end
		end
	end
endmodule

// ==== verif/tb_srx_exec_unit.sv ====
`timescale 1ns/1ps
module tb_srx_exec_unit;
	import srx_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic opValid = 1'b0;
	srx_op_t opCode = OP_NONE;
	logic [2:0] bitSelect = 3'h0;
	logic loadEn = 1'b1;
	logic [7:0] loadReg = 8'h00;
	logic [7:0] loadFlags = 8'h00;
	logic [7:0] operand, flagsIn, result, flagsOut, expReg, expFlags;
	logic resultValid, resultWrite, sleepRequest, watchdogRestart, debugBreak;
	int failures = 0;
	int total_checks = 0;
	// 125 MHz clock
	always #4 clk_sys = ~clk_sys;
	srx_exec_unit DUT (.clk_sys(clk_sys), .resetn(resetn), .opValid(opValid), .opCode(opCode),
		.operand(operand), .bitSelect(bitSelect), .flagsIn(flagsIn), .resultValid(resultValid),
		.result(result), .resultWrite(resultWrite), .flagsOut(flagsOut),
		.sleepRequest(sleepRequest), .watchdogRestart(watchdogRestart), .debugBreak(debugBreak));
	srx_core_model partner (.clk_sys(clk_sys), .loadEn(loadEn), .loadReg(loadReg),
		.loadFlags(loadFlags), .resultValid(resultValid), .resultWrite(resultWrite),
		.result(result), .flagsOut(flagsOut), .operand(operand), .flagsIn(flagsIn));
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// expected write flag, result and flags
	function automatic logic [16:0] expect_out(srx_op_t op, logic [7:0] r, logic [7:0] f,
		logic [2:0] b);
		logic [7:0] q;
		logic [7:0] g;
		logic w;
		logic c;
		q = r;
		g = f;
		w = 1'b0;
		c = f[FLAG_C];
		case (op)
			OP_ROTATE_LEFT_CARRY: begin q = {r[6:0], c}; c = r[7]; w = 1'b1; end
			OP_ROTATE_RIGHT_CARRY: begin q = {c, r[7:1]}; c = r[0]; w = 1'b1; end
			OP_LOGICAL_RIGHT_SHIFT: begin q = {1'b0, r[7:1]}; c = r[0]; w = 1'b1; end
			OP_ARITHMETIC_RIGHT_SHIFT: begin q = {r[7], r[7:1]}; c = r[0]; w = 1'b1; end
			OP_NIBBLE_SWAP: begin q = {r[3:0], r[7:4]}; w = 1'b1; end
			OP_BIT_TO_TRANSFER_FLAG: g[FLAG_T] = r[b];
			OP_TRANSFER_FLAG_TO_BIT: begin q[b] = f[FLAG_T]; w = 1'b1; end
			OP_OVERFLOW_FLAG_SET: g[FLAG_V] = 1'b1;
			OP_OVERFLOW_FLAG_CLEAR: g[FLAG_V] = 1'b0;
			OP_SIGN_FLAG_SET: g[FLAG_S] = 1'b1;
			OP_SIGN_FLAG_CLEAR: g[FLAG_S] = 1'b0;
			OP_HALF_CARRY_SET: g[FLAG_H] = 1'b1;
			OP_HALF_CARRY_CLEAR: g[FLAG_H] = 1'b0;
			OP_ZERO_FLAG_SET: g[FLAG_Z] = 1'b1;
			OP_ZERO_FLAG_CLEAR: g[FLAG_Z] = 1'b0;
			default: ;
		endcase
		if (w && op != OP_NIBBLE_SWAP && op != OP_TRANSFER_FLAG_TO_BIT) begin
			g[FLAG_C] = c;
			g[FLAG_N] = q[7];
			g[FLAG_V] = q[7] ^ c;
			g[FLAG_S] = c;
			g[FLAG_Z] = (q == 8'h00);
		end
		return {w, q, g};
	endfunction
	// preload register and flags through the partner
	task automatic load(input logic [7:0] r, input logic [7:0] f);
		loadEn = 1'b1;
		loadReg = r;
		loadFlags = f;
		@(posedge clk_sys);
		#1;
		loadEn = 1'b0;
		expReg = r;
		expFlags = f;
	endtask
	// one operation, its one-cycle answer, then the idle pass-through
	task automatic run(input srx_op_t op, input logic [2:0] b);
		logic [16:0] e;
		e = expect_out(op, expReg, expFlags, b);
		opValid = 1'b1;
		opCode = op;
		bitSelect = b;
		repeat (OP_CYCLES) @(posedge clk_sys);
		#1;
		opValid = 1'b0;
		check({resultValid, e[16:8], flagsOut}, {1'b1, resultWrite, result, e[7:0]});
		check({sleepRequest, watchdogRestart, debugBreak},
			{op == OP_SLEEP, op == OP_WATCHDOG_RESTART, op == OP_BREAK});
		if (e[16]) expReg = e[15:8];
		expFlags = e[7:0];
		repeat (2) @(posedge clk_sys);
		#1;
		check({resultValid, resultWrite, sleepRequest, watchdogRestart, debugBreak},
			5'h00);
		check({result, flagsOut}, {expReg, expFlags});
	endtask
	task automatic test_shifts;
		load(8'h81, 8'h01);
		run(OP_ROTATE_LEFT_CARRY, 3'h0);
		run(OP_ROTATE_RIGHT_CARRY, 3'h0);
		load(8'h01, 8'h00);
		run(OP_LOGICAL_RIGHT_SHIFT, 3'h0);
		load(8'hC3, 8'h00);
		run(OP_ARITHMETIC_RIGHT_SHIFT, 3'h0);
		run(OP_NIBBLE_SWAP, 3'h0);
		load(8'h96, 8'h00);
		repeat (9) run(OP_ROTATE_LEFT_CARRY, 3'h0);
		check(operand, 8'h96);
		$display("test shifts done");
	endtask
	task automatic test_bits;
		load(8'h80, 8'h00);
		run(OP_BIT_TO_TRANSFER_FLAG, 3'h7);
		run(OP_TRANSFER_FLAG_TO_BIT, 3'h0);
		run(OP_BIT_TO_TRANSFER_FLAG, 3'h1);
		run(OP_TRANSFER_FLAG_TO_BIT, 3'h7);
		$display("test bits done");
	endtask
	task automatic test_flags;
		load(8'h5A, 8'h00);
		run(OP_OVERFLOW_FLAG_SET, 3'h0);
		run(OP_SIGN_FLAG_SET, 3'h0);
		run(OP_HALF_CARRY_SET, 3'h0);
		run(OP_ZERO_FLAG_SET, 3'h0);
		load(8'h5A, 8'hFF);
		run(OP_OVERFLOW_FLAG_CLEAR, 3'h0);
		run(OP_SIGN_FLAG_CLEAR, 3'h0);
		run(OP_HALF_CARRY_CLEAR, 3'h0);
		run(OP_ZERO_FLAG_CLEAR, 3'h0);
		$display("test flags done");
	endtask
	task automatic test_control;
		load(8'h3C, 8'hA5);
		run(OP_SLEEP, 3'h0);
		run(OP_WATCHDOG_RESTART, 3'h0);
		run(OP_BREAK, 3'h0);
		run(OP_NONE, 3'h0);
		opValid = 1'b1;
		opCode = OP_SLEEP;
		resetn = 1'b0;
		@(posedge clk_sys);
		#1;
		opValid = 1'b0;
		check({resultValid, resultWrite, sleepRequest, result, flagsOut}, 19'h0);
		resetn = 1'b1;
		@(posedge clk_sys);
		#1;
		$display("test control done");
	endtask
	// verdict
	task automatic tally_and_finish;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		test_shifts;
		test_bits;
		test_flags;
		test_control;
		tally_and_finish;
	end
	// hang guard
	initial begin
		#20000;
		failures++;
		tally_and_finish;
	end
endmodule
